// file: rtl/cfesc_top.v
// Purpose: fault classification, escalation, lockup and sleep control
// Assumes: pipeline strobes are one-cycle pulses on clk; pins are async
// Notes:   AHB-Lite slave, zero wait states, always OKAY
// Operation
// - bus error on vector read raises hard fault, sets vector read flag
// - escalated configurable fault sets the escalated flag
// - fetch from never-execute region sets instr access flag, protection off too
// - bus faults set push, pop, fetch, exact and inexact flags separately
// - usage faults set six distinct flags
// - switch to unsupported instruction set gives usage fault, bad state flag
// - configurable faults have programmable priority and enables; hard fixed
// - fault in fault handler of same kind or priority not above escalates
// - fault in any handler of priority not above current escalates
// - fault with disabled handler is taken as hard fault
// - bus fault pushing for bus handler entry does not escalate
// - hard fault preempted only by reset and nmi, preempts the rest
// - capture faulting address for bus and protection faults only
// - hard fault inside hard fault handler locks up until reset
// - three sleep levels chosen by deep sleep select
// - wait for interrupt sleeps at once, unconditionally; here it does not if a fault arrives or is picked that cycle
// - wait for event sleeps if latch 0, else clears latch and continues
// - with sleep after handler set, return to thread sleeps at once
// - spurious wakes allowed; sleep can be re-entered any time
// - return code upper bits ones, low nibble 1, 9 or d, else invalid
// - fault not above mask level stays pending, not taken
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "cfesc_defines.vh"
module cfesc_top (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // pipeline side
  input  wire        faultValid,
  input  wire [3:0]  faultCause,
  input  wire        faultAddrValid,
  input  wire [31:0] faultAddr,
  input  wire        fetchNeverExec,
  input  wire        isaChange,
  input  wire        isaTargetOk,
  input  wire        handlerActive,
  input  wire [3:0]  execPrio,
  input  wire        curIsFault,
  input  wire [1:0]  curKind,
  input  wire        busHndPush,
  input  wire        inHardFault,
  input  wire        inNmi,
  input  wire        maskOn,
  input  wire [3:0]  maskPrio,
  input  wire        waitIrqExec,
  input  wire        waitEventExec,
  input  wire        returnValid,
  input  wire [31:0] returnCode,
  // pins
  input  wire        wakePin,
  input  wire        eventPin,
  // outputs
  output reg         takeFault,
  output reg  [1:0]  takeKind,
  output reg         lockup,
  output reg         sleeping,
  output reg  [1:0]  sleepLevel,
  output reg         eventLatch
);
  localparam [2:0] ST_RUN = 3'b001, ST_SLEEP = 3'b010, ST_LOCK = 3'b100;

  // kind of handler a cause belongs to
  function [1:0] causeKind;
    input [3:0] c;
    begin
      if (c == `CFESC_C_VECTOR)
        causeKind = `CFESC_KIND_HARD;
      else if (c <= `CFESC_C_PPOP)
        causeKind = `CFESC_KIND_PROT;
      else if (c <= `CFESC_C_INEXACT)
        causeKind = `CFESC_KIND_BUS;
      else
        causeKind = `CFESC_KIND_USE;
    end
  endfunction

  // kind number of a one-hot pick
  function [1:0] pickKind;
    input [3:0] oh;
    begin
      pickKind = oh[3] ? 2'h3 : oh[2] ? 2'h2 : oh[1] ? 2'h1 : 2'h0;
    end
  endfunction

  reg  [2:0]  state_q, state_d;
  reg  [1:0]  hfCause_q;
  reg  [3:0]  pfCause_q;
  reg  [4:0]  bfCause_q;
  reg  [5:0]  ufCause_q;
  reg  [31:0] pfAddr_q, bfAddr_q;
  reg  [2:0]  sysCtrl_q;
  reg  [2:0]  faultEn_q;
  reg  [11:0] faultPrio_q;
  reg  [3:0]  pend_q;
  reg         wrPend_q;
  reg  [7:0]  wrAddr_q;
  wire        wakeSync, eventSync;
  wire [1:0]  finalKind;
  wire        escalated, lockNow;

  // pins pass two flops first
  cfesc_sync #(.W(2)) uSync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .din  ({wakePin, eventPin}),
    .dout ({wakeSync, eventSync})
  );

  // effective new cause: pipeline fault, never-execute fetch, isa switch, return code check
  reg        newFault;
  reg [3:0]  newCause;
  reg        retOk, retThread;
  always @* begin
    retOk     = (returnCode[31:4] == `CFESC_RET_UPPER) &&
                (returnCode[3:0] == `CFESC_RET_HANDLER || returnCode[3:0] == `CFESC_RET_THR_MAIN ||
                 returnCode[3:0] == `CFESC_RET_THR_PROC);
    retThread = retOk && returnCode[3:0] != `CFESC_RET_HANDLER;
    newFault  = 1'b0;
    newCause  = faultCause;
    if (faultValid) begin
      newFault = 1'b1;
    end else if (fetchNeverExec) begin
      newFault = 1'b1;
      newCause = `CFESC_C_IACC;
    end else if (isaChange && !isaTargetOk) begin
      newFault = 1'b1;
      newCause = `CFESC_C_BADSTATE;
    end else if (returnValid && !retOk) begin
      newFault = 1'b1;
      newCause = `CFESC_C_BADRET;
    end
  end

  // escalation decision for the arriving fault, made once at arrival
  cfesc_escalate uEsc (
    .kind          (causeKind(newCause)),
    .faultEn       (faultEn_q),
    .faultPrio     (faultPrio_q),
    .handlerActive (handlerActive),
    .execPrio      (execPrio),
    .curIsFault    (curIsFault),
    .curKind       (curKind),
    .busHndPush    (busHndPush),
    .inHardFault   (inHardFault),
    .inNmi         (inNmi),
    .finalKind     (finalKind),
    .escalated     (escalated),
    .lockNow       (lockNow)
  );

  // pending kinds, masking and pick of the lowest-numbered unmasked kind
  reg [3:0] req, masked, pick;
  reg [3:0] p;
  integer   k;
  always @* begin
    req    = pend_q;
    masked = 4'h0;
    pick   = 4'h0;
    p      = 4'h0;
    if (newFault && !lockNow)
      req = req | (4'h1 << finalKind);
    for (k = 1; k < 4; k = k + 1) begin
      p         = faultPrio_q[(k - 1) * 4 +: 4];
      masked[k] = maskOn && (p >= maskPrio);
    end
    for (k = 3; k >= 0; k = k - 1)
      if (req[k] && !masked[k])
        pick = 4'h1 << k;
  end

  // cause flag sets for this cycle
  reg [1:0] hfSet;
  reg [3:0] pfSet;
  reg [4:0] bfSet;
  reg [5:0] ufSet;
  always @* begin
    hfSet = 2'h0;
    pfSet = 4'h0;
    bfSet = 5'h0;
    ufSet = 6'h0;
    if (newFault && state_q != ST_LOCK) begin
      case (newCause)
        `CFESC_C_VECTOR:   hfSet[0] = 1'b1;
        `CFESC_C_IACC:     pfSet[0] = 1'b1;
        `CFESC_C_DACC:     pfSet[1] = 1'b1;
        `CFESC_C_PPUSH:    pfSet[2] = 1'b1;
        `CFESC_C_PPOP:     pfSet[3] = 1'b1;
        `CFESC_C_BPUSH:    bfSet[0] = 1'b1;
        `CFESC_C_BPOP:     bfSet[1] = 1'b1;
        `CFESC_C_FETCH:    bfSet[2] = 1'b1;
        `CFESC_C_EXACT:    bfSet[3] = 1'b1;
        `CFESC_C_INEXACT:  bfSet[4] = 1'b1;
        `CFESC_C_COPROC:   ufSet[0] = 1'b1;
        `CFESC_C_UNDEF:    ufSet[1] = 1'b1;
        `CFESC_C_BADSTATE: ufSet[2] = 1'b1;
        `CFESC_C_BADRET:   ufSet[3] = 1'b1;
        `CFESC_C_UNALIGN:  ufSet[4] = 1'b1;
        default:           ufSet[5] = 1'b1;
      endcase
      hfSet[1] = escalated;
    end
  end

  // sleep and lockup state machine
  wire goSleep = waitIrqExec || (waitEventExec && !eventLatch) ||
                 (returnValid && retThread && sysCtrl_q[`CFESC_SC_AFTER_HND]);
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (newFault && lockNow)
          state_d = ST_LOCK;
        else if (goSleep && !newFault && pick == 4'h0)
          state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wakeSync || pick != 4'h0)
          state_d = ST_RUN;
      end
      ST_LOCK:  state_d = ST_LOCK;
      default:  state_d = ST_RUN;
    endcase
  end

  // bus write and read decode
  wire       addrOk = hsel && hready && htrans[1];
  wire       wrHit  = wrPend_q;
  wire [1:0] lvl    = !sysCtrl_q[`CFESC_SC_DEEP] ? `CFESC_LVL_SLEEP :
                      (sysCtrl_q[`CFESC_SC_BACKUP] ? `CFESC_LVL_BACKUP : `CFESC_LVL_WAIT);
  // status word: pending kinds, event latch, sleep level, spare bit, state
  wire [31:0] statusWord = {21'h0, pend_q, eventLatch, sleepLevel, 1'b0, state_q};

  reg [31:0] rdMux;
  always @* begin
    case (haddr)
      `CFESC_OFS_HARD_CAUSE: rdMux = {30'h0, hfCause_q};
      `CFESC_OFS_PROT_CAUSE: rdMux = {28'h0, pfCause_q};
      `CFESC_OFS_BUS_CAUSE:  rdMux = {27'h0, bfCause_q};
      `CFESC_OFS_USE_CAUSE:  rdMux = {26'h0, ufCause_q};
      `CFESC_OFS_PROT_ADDR:  rdMux = pfAddr_q;
      `CFESC_OFS_BUS_ADDR:   rdMux = bfAddr_q;
      `CFESC_OFS_SYS_CTRL:   rdMux = {29'h0, sysCtrl_q};
      `CFESC_OFS_HND_CTRL:   rdMux = {12'h0, faultPrio_q, 5'h0, faultEn_q};
      `CFESC_OFS_STATUS:     rdMux = statusWord;
      default:               rdMux = 32'h0;
    endcase
  end

  // write-one-to-clear masks, a new set in the same cycle wins
  wire [31:0] clr = hwdata;
  wire wHf = wrHit && wrAddr_q == `CFESC_OFS_HARD_CAUSE;
  wire wPf = wrHit && wrAddr_q == `CFESC_OFS_PROT_CAUSE;
  wire wBf = wrHit && wrAddr_q == `CFESC_OFS_BUS_CAUSE;
  wire wUf = wrHit && wrAddr_q == `CFESC_OFS_USE_CAUSE;

  // registers and outputs
  always @(posedge clk) begin
    if (srst) begin
      state_q     <= ST_RUN;
      hfCause_q   <= 2'h0;
      pfCause_q   <= 4'h0;
      bfCause_q   <= 5'h0;
      ufCause_q   <= 6'h0;
      pfAddr_q    <= 32'h0;
      bfAddr_q    <= 32'h0;
      sysCtrl_q   <= `CFESC_SYS_CTRL_RST;
      faultEn_q   <= `CFESC_HND_EN_RST;
      faultPrio_q <= `CFESC_HND_PRIO_RST;
      pend_q      <= 4'h0;
      wrPend_q    <= 1'b0;
      wrAddr_q    <= 8'h0;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      takeFault   <= 1'b0;
      takeKind    <= 2'h0;
      lockup      <= 1'b0;
      sleeping    <= 1'b0;
      sleepLevel  <= `CFESC_LVL_SLEEP;
      eventLatch  <= 1'b0;
    end else if (ce) begin
      // bus: writes land in the data phase, read data stands one cycle
      wrPend_q  <= addrOk && hwrite;
      wrAddr_q  <= haddr;
      hrdata    <= (addrOk && !hwrite) ? rdMux : 32'h0;
      hfCause_q <= (hfCause_q & ~(wHf ? clr[1:0] : 2'h0)) | hfSet;
      pfCause_q <= (pfCause_q & ~(wPf ? clr[3:0] : 4'h0)) | pfSet;
      bfCause_q <= (bfCause_q & ~(wBf ? clr[4:0] : 5'h0)) | bfSet;
      ufCause_q <= (ufCause_q & ~(wUf ? clr[5:0] : 6'h0)) | ufSet;
      if (wrHit && wrAddr_q == `CFESC_OFS_SYS_CTRL)
        sysCtrl_q <= hwdata[2:0];
      if (wrHit && wrAddr_q == `CFESC_OFS_HND_CTRL) begin
        faultEn_q   <= hwdata[2:0];
        faultPrio_q <= hwdata[`CFESC_HC_PRIO_LSB +: 12];
      end
      // address capture for protection and bus causes only
      if (newFault && faultAddrValid && |pfSet)
        pfAddr_q <= faultAddr;
      if (newFault && faultAddrValid && |bfSet)
        bfAddr_q <= faultAddr;
      // lockup drops pending kinds; the kind output holds between takes
      if (state_q == ST_LOCK) begin
        pend_q    <= 4'h0;
        takeFault <= 1'b0;
      end else begin
        pend_q    <= req & ~pick;
        takeFault <= |pick;
        if (|pick)
          takeKind <= pickKind(pick);
      end
      // event latch: pin sets, consuming wait for event clears, set wins
      if (eventSync)
        eventLatch <= 1'b1;
      else if (waitEventExec && eventLatch && state_q == ST_RUN)
        eventLatch <= 1'b0;
      state_q    <= state_d;
      lockup     <= state_d == ST_LOCK;
      sleeping   <= state_d == ST_SLEEP;
      if (state_q == ST_RUN && state_d == ST_SLEEP)
        sleepLevel <= lvl;
    end
  end
endmodule // cfesc_top
`default_nettype wire

// file: rtl/cfesc_defines.vh
// Purpose: constants of the fault escalation and sleep controller
// Assumes: included by cfesc_top and cfesc_escalate
// Notes:   byte offsets on the register bus, field positions, cause codes
`ifndef CFESC_DEFINES_VH
`define CFESC_DEFINES_VH
// register byte offsets
`define CFESC_OFS_HARD_CAUSE  8'h00
`define CFESC_OFS_PROT_CAUSE  8'h04
`define CFESC_OFS_BUS_CAUSE   8'h08
`define CFESC_OFS_USE_CAUSE   8'h0c
`define CFESC_OFS_PROT_ADDR   8'h10
`define CFESC_OFS_BUS_ADDR    8'h14
`define CFESC_OFS_SYS_CTRL    8'h18
`define CFESC_OFS_HND_CTRL    8'h1c
`define CFESC_OFS_STATUS      8'h20
// system control fields
`define CFESC_SC_AFTER_HND    0
`define CFESC_SC_DEEP         1
`define CFESC_SC_BACKUP       2
// handler control fields: enables in [2:0], priorities in nibbles
`define CFESC_HC_PRIO_LSB     8
`define CFESC_SYS_CTRL_RST    3'h0
`define CFESC_HND_EN_RST      3'h0
`define CFESC_HND_PRIO_RST    12'h000
// fault kinds
`define CFESC_KIND_HARD       2'h0
`define CFESC_KIND_PROT       2'h1
`define CFESC_KIND_BUS        2'h2
`define CFESC_KIND_USE        2'h3
// fault cause codes from the pipeline
`define CFESC_C_VECTOR        4'h0
`define CFESC_C_IACC          4'h1
`define CFESC_C_DACC          4'h2
`define CFESC_C_PPUSH         4'h3
`define CFESC_C_PPOP          4'h4
`define CFESC_C_BPUSH         4'h5
`define CFESC_C_BPOP          4'h6
`define CFESC_C_FETCH         4'h7
`define CFESC_C_EXACT         4'h8
`define CFESC_C_INEXACT       4'h9
`define CFESC_C_COPROC        4'ha
`define CFESC_C_UNDEF         4'hb
`define CFESC_C_BADSTATE      4'hc
`define CFESC_C_BADRET        4'hd
`define CFESC_C_UNALIGN       4'he
`define CFESC_C_ZERODIV       4'hf
// sleep levels
`define CFESC_LVL_SLEEP       2'h0
`define CFESC_LVL_WAIT        2'h1
`define CFESC_LVL_BACKUP      2'h2
// handler return code check
`define CFESC_RET_UPPER       28'hfffffff
`define CFESC_RET_HANDLER     4'h1
`define CFESC_RET_THR_MAIN    4'h9
`define CFESC_RET_THR_PROC    4'hd
`endif

// file: rtl/cfesc_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: din is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module cfesc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  // two stages, frozen with the clock enable
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // cfesc_sync
`default_nettype wire

// file: rtl/cfesc_escalate.v
// Purpose: decides the handler kind for one new fault
// Assumes: lower priority value means more urgent; hard fault beats all
// Notes:   purely combinational, sampled by the top on the fault pulse
`timescale 1ns/1ns
`default_nettype none
`include "cfesc_defines.vh"
module cfesc_escalate (
  input  wire [1:0]  kind,
  input  wire [2:0]  faultEn,
  input  wire [11:0] faultPrio,
  input  wire        handlerActive,
  input  wire [3:0]  execPrio,
  input  wire        curIsFault,
  input  wire [1:0]  curKind,
  input  wire        busHndPush,
  input  wire        inHardFault,
  input  wire        inNmi,
  output reg  [1:0]  finalKind,
  output reg         escalated,
  output reg         lockNow
);
  reg [3:0] prio;
  reg       enabled;

  // escalation choice
  always @* begin
    prio      = 4'h0;
    enabled   = 1'b1;
    escalated = 1'b0;
    finalKind = kind;
    if (kind != `CFESC_KIND_HARD) begin
      prio    = faultPrio[(kind - 2'h1) * 4 +: 4];
      enabled = faultEn[kind - 2'h1];
      if (busHndPush && kind == `CFESC_KIND_BUS)
        escalated = 1'b0;
      else if (!enabled)
        escalated = 1'b1;
      else if (curIsFault && curKind == kind)
        escalated = 1'b1;
      else if (handlerActive && prio >= execPrio)
        escalated = 1'b1;
    end
    if (escalated)
      finalKind = `CFESC_KIND_HARD;
    // a hard fault cannot preempt another hard fault or the nmi
    lockNow = (finalKind == `CFESC_KIND_HARD) && (inHardFault || inNmi);
  end
endmodule // cfesc_escalate
`default_nettype wire

// file: test/cfesc_top_sva.sv
// Purpose: port-level checks of the fault and sleep controller
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to cfesc_top after the module
`timescale 1ns/1ns
`default_nettype none
module cfesc_top_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        faultValid,
  input wire logic [3:0]  faultCause,
  input wire logic        fetchNeverExec,
  input wire logic        isaChange,
  input wire logic        inHardFault,
  input wire logic        inNmi,
  input wire logic        maskOn,
  input wire logic        waitIrqExec,
  input wire logic        waitEventExec,
  input wire logic        returnValid,
  input wire logic [31:0] returnCode,
  input wire logic        takeFault,
  input wire logic [1:0]  takeKind,
  input wire logic        lockup,
  input wire logic        sleeping,
  input wire logic        eventLatch
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // no other fault source competes in this cycle
  wire quiet = !faultValid && !fetchNeverExec && !isaChange && !lockup;

  a_vec_take: assert property (ce && faultValid && faultCause == 4'h0 && !lockup && !inHardFault && !inNmi
    |=> takeFault && takeKind == 2'h0) else $error("vector read fault not taken as hard fault");
  a_lock_enter: assert property (ce && faultValid && faultCause == 4'h0 && inHardFault |=> lockup)
    else $error("hard fault in hard handler did not lock up");
  a_lock_hold: assert property (!srst && lockup |=> lockup) else $error("lockup left without reset");
  a_lock_quiet: assert property (lockup |=> !takeFault) else $error("handler taken in lockup");
  a_wfi_sleep: assert property (ce && waitIrqExec && quiet && !returnValid && !takeFault |=> sleeping)
    else $error("wait for interrupt did not sleep");
  a_wfe_skip: assert property (ce && waitEventExec && eventLatch && !sleeping |=> !sleeping)
    else $error("wait for event slept with latch set");
  a_reset_clean: assert property (disable iff (1'b0) ce && srst |=> !lockup && !sleeping && !takeFault)
    else $error("reset left state set");
  a_bad_ret: assert property (ce && returnValid && returnCode[31:4] == 28'hfffffff && quiet && !maskOn
    && !inHardFault && !inNmi && !(returnCode[3:0] inside {4'h1, 4'h9, 4'hd}) |=> takeFault)
    else $error("invalid return code not faulted");

  c_bus_take: cover property (takeFault && takeKind == 2'h2);
  c_lockup: cover property ($rose(lockup));
  c_sleep: cover property ($rose(sleeping));
endmodule // cfesc_top_sva

bind cfesc_top cfesc_top_sva i_sva (.clk, .srst, .ce, .faultValid, .faultCause, .fetchNeverExec, .isaChange,
  .inHardFault, .inNmi, .maskOn, .waitIrqExec, .waitEventExec, .returnValid, .returnCode, .takeFault, .takeKind,
  .lockup, .sleeping, .eventLatch);
`default_nettype wire

// file: test/cfesc_pipe_model.sv
// Purpose: pipeline, bus and protection side seen by the controller
// Assumes: one-cycle strobes launched after a rising edge
// Notes:   released data lines show the inverse of the strobe's c and a arguments
`timescale 1ns/1ns
`default_nettype none
module cfesc_pipe_model (
  input wire logic  clk,
  output logic        faultValid,
  output logic [3:0]  faultCause,
  output logic        faultAddrValid,
  output logic [31:0] faultAddr,
  output logic        fetchNeverExec,
  output logic        isaChange,
  output logic        isaTargetOk,
  output logic        handlerActive,
  output logic [3:0]  execPrio,
  output logic        curIsFault,
  output logic [1:0]  curKind,
  output logic        busHndPush,
  output logic        inHardFault,
  output logic        inNmi,
  output logic        waitIrqExec,
  output logic        waitEventExec,
  output logic        returnValid,
  output logic [31:0] returnCode
);
  // idle core context at time zero
  initial begin
    {faultValid, faultAddrValid, fetchNeverExec, isaChange, handlerActive, curIsFault} = 6'h00;
    {busHndPush, inHardFault, inNmi, waitIrqExec, waitEventExec, returnValid} = 6'h00;
    {faultCause, execPrio, curKind} = 10'h000;
    {faultAddr, returnCode} = 64'h0;
    isaTargetOk = 1'b1;
  end

  // one strobe of kind k: 0 fault, 1 fetch, 2 isa, 3 return, 4 wfi, 5 wfe
  task fire(input logic [2:0] k, input logic [3:0] c, input logic [31:0] a);
    @(posedge clk);
    case (k)
      3'h0: {faultValid, faultAddrValid, faultCause, faultAddr} <= {2'h3, c, a};
      3'h1: fetchNeverExec <= 1'b1;
      3'h2: isaChange <= 1'b1;
      3'h3: {returnValid, returnCode} <= {1'b1, a};
      3'h4: waitIrqExec <= 1'b1;
      default: waitEventExec <= 1'b1;
    endcase
    @(posedge clk);
    {faultValid, faultAddrValid, fetchNeverExec, isaChange, returnValid, waitIrqExec, waitEventExec} <= 7'h00;
    {faultCause, faultAddr, returnCode} <= {~c, ~a, ~a}; // stale values must not look valid
  endtask
endmodule // cfesc_pipe_model
`default_nettype wire

// file: test/test_cfesc_top.sv
// Purpose: self-checking bench of the fault and sleep controller
// Assumes: zero-wait register bus, registered outputs
// Notes:   takes and read data checked by a monitor against queued notes
`timescale 1ns/1ns
`default_nettype none
module test_cfesc_top;
  logic        clk, srst, wakePin, eventPin, hwrite, rdPh, maskOn;
  logic [1:0]  htrans;
  logic [3:0]  maskPrio;
  logic [7:0]  haddr;
  logic [31:0] hwdata, a;
  int          fail_count, checked, seed;
  logic [1:0]  expQ[$];
  logic [31:0] rdQ[$];
  wire         faultValid, faultAddrValid, fetchNeverExec, isaChange, isaTargetOk, handlerActive, curIsFault;
  wire         busHndPush, inHardFault, inNmi, waitIrqExec, waitEventExec, returnValid;
  wire         hreadyout, hresp, takeFault, lockup, sleeping, eventLatch;
  wire [1:0]   curKind, takeKind, sleepLevel;
  wire [3:0]   faultCause, execPrio;
  wire [31:0]  faultAddr, returnCode, hrdata;

  cfesc_pipe_model i_pipe (.clk, .faultValid, .faultCause, .faultAddrValid, .faultAddr, .fetchNeverExec,
    .isaChange, .isaTargetOk, .handlerActive, .execPrio, .curIsFault, .curKind, .busHndPush, .inHardFault,
    .inNmi, .waitIrqExec, .waitEventExec, .returnValid, .returnCode);
  cfesc_top i_dut (.clk, .srst, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .faultValid, .faultCause, .faultAddrValid, .faultAddr,
    .fetchNeverExec, .isaChange, .isaTargetOk, .handlerActive, .execPrio, .curIsFault, .curKind, .busHndPush,
    .inHardFault, .inNmi, .maskOn, .maskPrio, .waitIrqExec, .waitEventExec, .returnValid,
    .returnCode, .wakePin, .eventPin, .takeFault, .takeKind, .lockup, .sleeping, .sleepLevel, .eventLatch);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task print_verdict;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one single-word transfer, address phase held until ready
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task rd(input logic [7:0] ad, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask

  task f(input logic [2:0] k, input logic [3:0] c, input logic [31:0] ad, input logic [1:0] ek);
    expQ.push_back(ek);
    i_pipe.fire(k, c, ad);
  endtask

  // wake pin pulse, then the core must be running again
  task wake;
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (4) @(posedge clk);
    wakePin <= 1'b0;
    @(negedge clk);
    check(sleeping, 32'h0);
  endtask

  // monitor: each take and each read data phase against the oldest note
  always @(posedge clk) begin
    if (takeFault === 1'b1) check(takeKind, expQ.size() ? expQ.pop_front() : 2'bxx);
    if (rdPh && hreadyout === 1'b1) begin
      check(hrdata, rdQ.pop_front());
      check(hresp, 32'h0);
      rdPh = 1'b0;
    end
    if (htrans === 2'h2 && hwrite === 1'b0 && hreadyout === 1'b1) rdPh = 1'b1;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict;
  end

  initial begin
    {seed, fail_count, checked, rdPh} = {32'd28, 64'd0, 1'b0};
    {srst, wakePin, eventPin, maskOn, hwrite, htrans, haddr, hwdata, a, maskPrio} = {1'b1, 82'h0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    rd(8'h24, 32'h0);
    $display("test reset values done");
    // event latch set by the pin is consumed without sleeping
    eventPin <= 1'b1;
    @(posedge clk);
    eventPin <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(eventLatch, 32'h1);
    i_pipe.fire(3'h5, 4'h0, 32'h0);
    @(negedge clk);
    check(sleeping, 32'h0);
    check(eventLatch, 32'h0);
    i_pipe.fire(3'h5, 4'h0, 32'h0);
    @(negedge clk);
    check(sleeping, 32'h1);
    wake;
    // sleep level per select bits, re-entered after each wake
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h18, 32'(i * 2 + (i == 2 ? 2 : 0)));
      i_pipe.fire(3'h4, 4'h0, 32'h0);
      @(negedge clk);
      check(sleeping, 32'h1);
      check(sleepLevel, 32'(i));
      wake;
    end
    bus(1'b1, 8'h18, 32'h1);
    i_pipe.fire(3'h3, 4'h0, 32'hfffffff9);
    @(negedge clk);
    check(sleeping, 32'h1);
    wake;
    bus(1'b1, 8'h18, 32'h0);
    $display("test sleep done");
    // classification, flags and addresses
    bus(1'b1, 8'h1c, 32'h00032107);
    rd(8'h1c, 32'h00032107);
    for (int c = 5; c < 10; c++) begin
      a = $random(seed);
      f(3'h0, 4'(c), a, 2'h2);
    end
    rd(8'h08, 32'h1f);
    rd(8'h14, a);
    for (int c = 10; c < 16; c++) f(3'h0, 4'(c), $random(seed), 2'h3);
    rd(8'h0c, 32'h3f);
    bus(1'b1, 8'h0c, 32'h3f);
    rd(8'h0c, 32'h0);
    i_pipe.isaTargetOk <= 1'b0;
    f(3'h2, 4'h0, 32'h0, 2'h3);
    f(3'h3, 4'h0, 32'hfffffff3, 2'h3);
    i_pipe.fire(3'h3, 4'h0, 32'hfffffff1);
    rd(8'h0c, 32'h0c);
    a = $random(seed);
    f(3'h1, 4'h0, 32'h0, 2'h1);
    for (int c = 3; c < 5; c++) f(3'h0, 4'(c), $random(seed), 2'h1);
    f(3'h0, 4'h2, a, 2'h1);
    rd(8'h04, 32'hf);
    rd(8'h10, a);
    f(3'h0, 4'h0, 32'h0, 2'h0);
    rd(8'h00, 32'h1);
    // masked fault waits in the status word until the mask drops
    {maskOn, maskPrio} <= 5'h12;
    i_pipe.fire(3'h0, 4'hb, 32'h0);
    rd(8'h20, 32'h401);
    expQ.push_back(2'h3);
    maskOn <= 1'b0;
    $display("test causes done");
    // escalation: disabled handler, priority, same kind, push exemption
    bus(1'b1, 8'h1c, 32'h00032105);
    f(3'h0, 4'h8, 32'h0, 2'h0);
    rd(8'h00, 32'h3);
    bus(1'b1, 8'h1c, 32'h00032107);
    {i_pipe.handlerActive, i_pipe.execPrio} <= 5'h12;
    f(3'h0, 4'hb, 32'h0, 2'h0);
    {i_pipe.curIsFault, i_pipe.curKind, i_pipe.execPrio} <= 7'h63;
    f(3'h0, 4'h8, 32'h0, 2'h0);
    i_pipe.busHndPush <= 1'b1;
    f(3'h0, 4'h5, 32'h0, 2'h2);
    $display("test escalation done");
    // lockup holds until reset
    i_pipe.inHardFault <= 1'b1;
    i_pipe.fire(3'h0, 4'h0, 32'h0);
    @(negedge clk);
    check(lockup, 32'h1);
    i_pipe.fire(3'h0, 4'h8, 32'h0);
    @(negedge clk);
    check(lockup, 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(lockup, 32'h0);
    check(expQ.size(), 32'h0);
    $display("test lockup done");
    print_verdict;
  end
endmodule // test_cfesc_top
`default_nettype wire
